/* wrsl_pkg.sv */
// Constants, types and layouts for the working register / stack limit unit.
// Assumes a single core clock; shared by the register file, the stack model and the bench.
package wrsl_pkg;
    localparam logic [15:0] WRSL_STKPTR_RESET = 16'h0800;
    localparam logic [15:0] WRSL_STK_FLOOR = 16'h0800;
    localparam logic [15:0] WRSL_STK_STEP = 16'h0002;
    localparam logic [3:0] WRSL_STKPTR_IDX = 4'hf;
    localparam logic [3:0] WRSL_FP_IDX = 4'he;
    localparam logic [3:0] WRSL_IMPL_IDX = 4'h0;
    localparam int WRSL_SHADOW_TOP = 14;
    localparam logic [5:0] WRSL_IDX_LIMIT = 6'h10;
    localparam logic [7:0] WRSL_OFS_WREG0 = 8'h00;
    localparam logic [7:0] WRSL_OFS_LIMIT = 8'h40;

    typedef struct packed {
        logic half_carry;
        logic negative;
        logic overflow;
        logic sticky_zero;
        logic carry;
    } wrsl_flags_t;

    typedef struct packed {
        logic active;
        logic [23:0] start_addr;
        logic [23:0] end_addr;
        logic [15:0] iter_count;
    } wrsl_loop_t;

    typedef struct packed {
        logic [7:0] table_page;
        logic [7:0] visibility_page;
        wrsl_flags_t flags;
    } wrsl_ctx_t;

    typedef enum logic {
        WRSL_IDLE,
        WRSL_PC_HI
    } wrsl_state_t;
endpackage

/* wrsl_regfile.sv */
// Working register file with shadow bank, stack pointer and limit checking.
// Assumes the core issues stack, shadow and loop events one at a time and
// holds off push/pop while busy is high; APB master follows usual protocol.
module wrsl_regfile
    import wrsl_pkg::*;
#(
    parameter int APB_AW = 8
)
(
    input wire logic mclk,
    input wire logic rst,
    input wire logic ce,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [APB_AW-1:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [3:0] rd_addr_a,
    input wire logic [3:0] rd_addr_b,
    output logic [15:0] rd_data_a,
    output logic [15:0] rd_data_b,
    input wire logic wr_en,
    input wire logic wr_byte,
    input wire logic [3:0] wr_addr,
    input wire logic [15:0] wr_data,
    input wire logic push_en,
    input wire logic [15:0] push_data,
    input wire logic pop_en,
    input wire logic pc_push_call,
    input wire logic pc_push_exc,
    input wire logic [23:0] pc_value,
    input wire logic [7:0] status_low_byte,
    input wire logic ext_ea_valid,
    input wire logic [15:0] ext_ea,
    input wire logic shadow_push,
    input wire logic shadow_pop,
    input wire wrsl_ctx_t ctx_in,
    output wrsl_ctx_t ctx_out,
    output logic ctx_restore,
    input wire logic loop_start,
    input wire logic loop_end,
    input wire wrsl_loop_t loop_in,
    output wrsl_loop_t loop_out,
    output logic loop_restore,
    output logic stk_req,
    output logic stk_we,
    output logic [15:0] stk_addr,
    output logic [15:0] stk_wdata,
    output logic stk_busy,
    output logic ovf_trap,
    output logic unf_trap,
    output logic [15:0] stack_top_pointer,
    output logic [15:0] frame_pointer_reg,
    output logic [15:0] implied_working_reg
);
    if (APB_AW < 8)
    begin : g_bad_aw
        $error("APB_AW too small for the register map");
    end

    function automatic logic [15:0] merge_bytes(input logic [15:0] old_v,
        input logic [15:0] new_v, input logic [1:0] lanes);
        merge_bytes = {lanes[1] ? new_v[15:8] : old_v[15:8],
                       lanes[0] ? new_v[7:0] : old_v[7:0]};
    endfunction

    function automatic logic is_overflow(input logic [15:0] ea,
        input logic [15:0] limit, input logic armed);
        is_overflow = armed && (ea > limit);
    endfunction

    logic [15:0] w_reg [16];
    logic [15:0] w_next [16];
    logic [15:0] sh_w_reg [WRSL_SHADOW_TOP+1];
    wrsl_ctx_t sh_ctx_reg;
    wrsl_loop_t sh_loop_reg;
    logic [15:0] stack_limit_reg;
    logic lim_armed_reg;
    wrsl_state_t state_reg;
    logic [15:0] pc_hi_reg;
    logic pready_reg, pslverr_reg;
    logic [31:0] prdata_reg;
    logic [15:0] rd_a_reg, rd_b_reg;
    logic stk_req_reg, stk_we_reg, stk_busy_reg;
    logic [15:0] stk_addr_reg, stk_wdata_reg;
    logic ovf_reg, unf_reg;
    wrsl_ctx_t ctx_out_reg;
    logic ctx_restore_reg;
    wrsl_loop_t loop_out_reg;
    logic loop_restore_reg;

    // APB decode
    wire logic [5:0] apb_idx = paddr[7:2];
    wire logic apb_w_hit = (paddr[1:0] == 2'b00) && (apb_idx < 6'h10);
    wire logic apb_lim_hit = (paddr[1:0] == 2'b00) &&
        (apb_idx == WRSL_IDX_LIMIT);
    wire logic apb_hit = apb_w_hit || apb_lim_hit;
    wire logic apb_setup = psel && !penable;
    wire logic apb_done = psel && penable && pready_reg;
    wire logic apb_wr = apb_done && pwrite && apb_hit;
    wire logic [3:0] apb_widx = apb_idx[3:0];
    wire logic [15:0] apb_rd_word = apb_w_hit ? w_reg[apb_widx] :
        (apb_lim_hit ? stack_limit_reg : 16'h0000);

    // Stack address generation
    wire logic [15:0] top_ptr = w_reg[WRSL_STKPTR_IDX];
    wire logic idle = (state_reg == WRSL_IDLE);
    wire logic pc_go = idle && (pc_push_call || pc_push_exc);
    wire logic push_go = idle && !pc_go && push_en;
    wire logic pop_go = idle && !pc_go && !push_en && pop_en;
    wire logic hi_go = (state_reg == WRSL_PC_HI);
    wire logic up_go = pc_go || push_go || hi_go;
    wire logic stk_go = up_go || pop_go;
    wire logic [15:0] stk_ea = pop_go ? (top_ptr - WRSL_STK_STEP) : top_ptr;
    wire logic [15:0] top_step = up_go ? (top_ptr + WRSL_STK_STEP) :
        (top_ptr - WRSL_STK_STEP);
    // PC low word with bit 0 clear
    wire logic [15:0] pc_lo_word = {pc_value[15:1], 1'b0};
    wire logic [15:0] pc_call_hi = {8'h00, 1'b0, pc_value[22:16]};
    // exception pairs status low byte with PC bits 22:16, bit 23 dropped
    // status low byte taken as the low status byte
    wire logic [15:0] pc_exc_hi = {status_low_byte, 1'b0, pc_value[22:16]};
    wire logic [15:0] stk_wd_sel = pc_go ? pc_lo_word :
        (hi_go ? pc_hi_reg : push_data);
    // limit compare on every stack-pointer address
    wire logic ovf_next = (stk_go && is_overflow(stk_ea, stack_limit_reg,
        lim_armed_reg)) || (ext_ea_valid && is_overflow(ext_ea,
        stack_limit_reg, lim_armed_reg));
    // floor compare on every stack-pointer address
    wire logic unf_next = (stk_go && (stk_ea < WRSL_STK_FLOOR)) ||
        (ext_ea_valid && (ext_ea < WRSL_STK_FLOOR));
    wire logic [15:0] wr_hi_old = w_reg[wr_addr];

    always_comb
    begin
        for (int i = 0; i < 16; i++)
            w_next[i] = w_reg[i];
        // byte lanes reach each register half
        if (apb_wr && apb_w_hit)
            w_next[apb_widx] = merge_bytes(w_reg[apb_widx], pwdata[15:0],
                pstrb[1:0]);
        // byte operation keeps the high byte
        if (wr_en)
            w_next[wr_addr] = wr_byte ? {w_reg[wr_addr][15:8], wr_data[7:0]} :
                wr_data;
        // shadow pop restores registers 0 to 14
        if (shadow_pop)
            for (int i = 0; i <= WRSL_SHADOW_TOP; i++)
                w_next[i] = sh_w_reg[i];
        if (stk_go)
            w_next[WRSL_STKPTR_IDX] = top_step;
        // stack pointer bit 0 held clear
        w_next[WRSL_STKPTR_IDX][0] = 1'b0;
    end

    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            for (int i = 0; i < 16; i++)
                w_reg[i] <= (i == 15) ? WRSL_STKPTR_RESET : 16'h0000;
        end
        else if (ce)
        begin
            for (int i = 0; i < 16; i++)
                w_reg[i] <= w_next[i];
        end
    end

    // shadows load only on shadow push and loop start
    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            for (int i = 0; i <= WRSL_SHADOW_TOP; i++)
                sh_w_reg[i] <= 16'h0000;
            sh_ctx_reg <= '0;
            sh_loop_reg <= '0;
        end
        else if (ce)
        begin
            if (shadow_push)
            begin
                for (int i = 0; i <= WRSL_SHADOW_TOP; i++)
                    sh_w_reg[i] <= w_reg[i];
                sh_ctx_reg <= ctx_in;
            end
            if (loop_start)
                sh_loop_reg <= loop_in;
        end
    end

    // limit register carries no reset value
    always_ff @(posedge mclk)
    begin
        if (ce && apb_wr && apb_lim_hit)
            stack_limit_reg <= {pwdata[15:8], pwdata[7:1], 1'b0};
    end

    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            lim_armed_reg <= 1'b0;
            state_reg <= WRSL_IDLE;
            pc_hi_reg <= 16'h0000;
        end
        else if (ce)
        begin
            if (apb_wr && apb_lim_hit)
                lim_armed_reg <= 1'b1;
            case (state_reg)
                WRSL_IDLE:
                begin
                    if (pc_go)
                    begin
                        state_reg <= WRSL_PC_HI;
                        pc_hi_reg <= pc_push_exc ? pc_exc_hi : pc_call_hi;
                    end
                end
                WRSL_PC_HI:
                    state_reg <= WRSL_IDLE;
                default:
                    state_reg <= WRSL_IDLE;
            endcase
        end
    end

    // APB slave: no wait states, registered answer
    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            pready_reg <= 1'b0;
            pslverr_reg <= 1'b0;
            prdata_reg <= 32'h00000000;
        end
        else if (ce)
        begin
            pready_reg <= apb_setup;
            pslverr_reg <= apb_setup && !apb_hit;
            if (apb_setup)
                prdata_reg <= {16'h0000, apb_rd_word};
        end
    end

    // trap pulses share the cycle of the stack address
    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            stk_req_reg <= 1'b0;
            stk_we_reg <= 1'b0;
            stk_addr_reg <= 16'h0000;
            stk_wdata_reg <= 16'h0000;
            stk_busy_reg <= 1'b0;
            ovf_reg <= 1'b0;
            unf_reg <= 1'b0;
            rd_a_reg <= 16'h0000;
            rd_b_reg <= 16'h0000;
        end
        else if (ce)
        begin
            stk_req_reg <= stk_go;
            stk_we_reg <= up_go;
            stk_addr_reg <= stk_ea;
            stk_wdata_reg <= stk_wd_sel;
            stk_busy_reg <= pc_go;
            ovf_reg <= ovf_next;
            unf_reg <= unf_next;
            rd_a_reg <= w_reg[rd_addr_a];
            rd_b_reg <= w_reg[rd_addr_b];
        end
    end

    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            ctx_out_reg <= '0;
            ctx_restore_reg <= 1'b0;
            loop_out_reg <= '0;
            loop_restore_reg <= 1'b0;
        end
        else if (ce)
        begin
            ctx_restore_reg <= shadow_pop;
            if (shadow_pop)
                ctx_out_reg <= sh_ctx_reg;
            loop_restore_reg <= loop_end;
            if (loop_end)
                loop_out_reg <= sh_loop_reg;
        end
    end

    assign prdata = prdata_reg;
    assign pready = pready_reg;
    assign pslverr = pslverr_reg;
    assign rd_data_a = rd_a_reg;
    assign rd_data_b = rd_b_reg;
    assign ctx_out = ctx_out_reg;
    assign ctx_restore = ctx_restore_reg;
    assign loop_out = loop_out_reg;
    assign loop_restore = loop_restore_reg;
    assign stk_req = stk_req_reg;
    assign stk_we = stk_we_reg;
    assign stk_addr = stk_addr_reg;
    assign stk_wdata = stk_wdata_reg;
    assign stk_busy = stk_busy_reg;
    assign ovf_trap = ovf_reg;
    assign unf_trap = unf_reg;
    assign stack_top_pointer = w_reg[WRSL_STKPTR_IDX];
    // frame pointer view of register 14
    assign frame_pointer_reg = w_reg[WRSL_FP_IDX];
    // implied register view of register 0
    assign implied_working_reg = w_reg[WRSL_IMPL_IDX];

    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (rst);

    chk_stkptr_bit0: assert property (stack_top_pointer[0] == 1'b0)
        else $error("stack pointer bit 0 set");
    chk_stkptr_reset: assert property (disable iff (1'b0)
        $fell(rst) |-> stack_top_pointer == WRSL_STKPTR_RESET)
        else $error("stack pointer reset value wrong");
    chk_push_increment: assert property (ce && push_go && !ovf_next
        |=> stk_req && stk_we && stack_top_pointer == stk_addr + 16'h0002)
        else $error("push did not post-increment");
    chk_pop_decrement: assert property (ce && pop_go
        |=> stk_req && !stk_we && stack_top_pointer == stk_addr)
        else $error("pop did not pre-decrement");
    chk_byte_high_keep: assert property (ce && wr_en && wr_byte
        && wr_addr != WRSL_STKPTR_IDX && !shadow_pop
        |=> w_reg[$past(wr_addr)][15:8] == $past(wr_hi_old[15:8]))
        else $error("byte write changed high byte");
    chk_call_msb_zero: assert property (ce && pc_go && pc_push_call
        && !pc_push_exc ##1 ce |=> stk_wdata[15:7] == 9'h000)
        else $error("call push top byte not zero extended");
    chk_exc_status_byte: assert property (ce && pc_go && pc_push_exc
        ##1 ce |=> stk_wdata[15:8] == $past(status_low_byte, 2))
        else $error("exception push lacks status byte");
    chk_loop_pop_back: assert property (ce && loop_end && !loop_start
        |=> loop_restore && loop_out == $past(sh_loop_reg))
        else $error("loop state not restored");
    chk_ext_overflow: assert property (ce && ext_ea_valid
        && lim_armed_reg && ext_ea > stack_limit_reg |=> ovf_trap)
        else $error("overflow trap missing");
    chk_ext_underflow: assert property (ce && ext_ea_valid
        && ext_ea < WRSL_STK_FLOOR |=> unf_trap)
        else $error("underflow trap missing");
    chk_limit_bit0: assert property (lim_armed_reg
        |-> !stack_limit_reg[0])
        else $error("stack limit bit 0 set");

    cov_pc_exc_push: cover property (ce && pc_go && pc_push_exc ##1 hi_go);
    cov_overflow_trap: cover property (ovf_trap && stk_req);
    cov_shadow_roundtrip: cover property (shadow_push ##[1:20] shadow_pop);
    cov_apb_write: cover property (apb_wr && apb_w_hit);
endmodule

/* wrsl_stack_model.sv */
// Stack memory on the core side of the register file.
// Assumes at most one stack access per cycle, word aligned.
module wrsl_stack_model
    import wrsl_pkg::*;
(
    input wire logic mclk,
    input wire logic stk_req,
    input wire logic stk_we,
    input wire logic [15:0] stk_addr,
    input wire logic [15:0] stk_wdata,
    input wire logic [15:0] look_addr,
    output logic [15:0] look_data
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [15:0] mem [0:32767];
    always_ff @(posedge mclk)
    begin
        if (stk_req && stk_we)
            mem[stk_addr[15:1]] <= stk_wdata;
    end
    assign look_data = mem[look_addr[15:1]];
endmodule

/* tb_working_regs_stack_limit_unit.sv */
// Self-checking bench for the working register file and stack checks.
// Assumes the APB slave answers in one access cycle and 40 MHz mclk.
module tb_working_regs_stack_limit_unit import wrsl_pkg::*; ();
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [23:0] PCV = 24'hc34567;
    logic mclk = 1'b0;
    logic rst = 1'b1;
    logic ce = 1'b1;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [3:0] pstrb = 4'h0;
    logic [31:0] prdata, rdat;
    logic pready, pslverr, rerr;
    logic [3:0] rd_addr_a = 4'h0, rd_addr_b = 4'h0, wr_addr = 4'h0;
    logic [15:0] rd_data_a, rd_data_b;
    logic wr_en = 1'b0, wr_byte = 1'b0, push_en = 1'b0, pop_en = 1'b0;
    logic [15:0] wr_data = 16'h0, push_data = 16'h0, ext_ea = 16'h0;
    logic pc_push_call = 1'b0, pc_push_exc = 1'b0, ext_ea_valid = 1'b0;
    logic shadow_push = 1'b0, shadow_pop = 1'b0;
    logic loop_start = 1'b0, loop_end = 1'b0;
    logic [23:0] pc_value = 24'h0;
    logic [7:0] status_low_byte = 8'h00;
    wrsl_ctx_t ctx_in = '0, ctx_out;
    wrsl_loop_t loop_in = '0, loop_out;
    logic ctx_restore, loop_restore, stk_req, stk_we, stk_busy;
    logic ovf_trap, unf_trap, o1, u1;
    logic [15:0] stk_addr, stk_wdata, stack_top_pointer;
    logic [15:0] frame_pointer_reg, implied_working_reg;
    logic [15:0] look_addr = 16'h0, look_data;
    int n_errors = 0;
    int checks_done = 0;

    always #12.5 mclk = ~mclk;

    wrsl_regfile #(.APB_AW(8)) i_dut (.mclk, .rst, .ce, .psel, .penable,
        .pwrite, .paddr, .pwdata, .pstrb, .prdata, .pready, .pslverr,
        .rd_addr_a, .rd_addr_b, .rd_data_a, .rd_data_b, .wr_en, .wr_byte,
        .wr_addr, .wr_data, .push_en, .push_data, .pop_en, .pc_push_call,
        .pc_push_exc, .pc_value, .status_low_byte, .ext_ea_valid, .ext_ea,
        .shadow_push, .shadow_pop, .ctx_in, .ctx_out, .ctx_restore,
        .loop_start, .loop_end, .loop_in, .loop_out, .loop_restore,
        .stk_req, .stk_we, .stk_addr, .stk_wdata, .stk_busy, .ovf_trap,
        .unf_trap, .stack_top_pointer, .frame_pointer_reg,
        .implied_working_reg);

    wrsl_stack_model i_mem (.mclk, .stk_req, .stk_we, .stk_addr,
        .stk_wdata, .look_addr, .look_data);

    task automatic check(input string what, input logic [64:0] seen,
        input logic [64:0] exp);
        checks_done++;
        if (seen !== exp)
        begin
            n_errors++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic stop_test();
        $display("checks %0d mismatches %0d", checks_done, n_errors);
        if (n_errors == 0 && checks_done > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    task automatic apb(input logic w, input logic [7:0] a,
        input logic [31:0] d, input logic [3:0] s);
        int n;
        @(posedge mclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        pstrb <= s;
        @(posedge mclk);
        penable <= 1'b1;
        n = 0;
        do
        begin
            @(posedge mclk);
            n++;
        end
        while (pready !== 1'b1 && n < 16);
        rdat = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (pready !== 1'b1)
        begin
            n_errors++;
            $display("wrong value pready expected 1 seen %b", pready);
            stop_test();
        end
    endtask

    task automatic rreg(input logic [7:0] a, input logic [31:0] exp,
        input string nm);
        apb(1'b0, a, 32'h0, 4'h0);
        check(nm, rdat, exp);
    endtask

    // Pulses one core event; returns when the answer cycle can be read
    task automatic ev(input int k);
        @(posedge mclk);
        push_en <= (k == 0);
        pop_en <= (k == 1);
        pc_push_call <= (k == 2);
        pc_push_exc <= (k == 3);
        ext_ea_valid <= (k == 4);
        shadow_push <= (k == 5);
        shadow_pop <= (k == 6);
        loop_start <= (k == 7);
        loop_end <= (k == 8);
        @(posedge mclk);
        {push_en, pop_en, pc_push_call, pc_push_exc, ext_ea_valid} <= 5'h0;
        {shadow_push, shadow_pop, loop_start, loop_end} <= 4'h0;
        @(posedge mclk);
    endtask

    // Trap for a checked address stands for exactly one cycle
    task automatic ea(input logic [15:0] a, input logic eo, input logic eu);
        ext_ea <= a;
        ev(4);
        o1 = ovf_trap;
        u1 = unf_trap;
        @(posedge mclk);
        check("ea traps", {o1, u1}, {eo, eu});
        check("ea trap pulse", {ovf_trap, unf_trap}, 2'b00);
    endtask

    task automatic fill(input logic [15:0] base);
        for (int i = 0; i < 15; i++)
        begin
            @(posedge mclk);
            wr_en <= 1'b1;
            wr_addr <= 4'(i);
            wr_data <= base + 16'(i);
        end
        @(posedge mclk);
        wr_en <= 1'b0;
    endtask

    initial
    begin
        repeat (4) @(posedge mclk);
        check("stkptr in reset", stack_top_pointer, 16'h0800);
        rst <= 1'b0;
        rreg(8'h3c, 32'h0800, "reg15 after reset");
        apb(1'b1, 8'h0c, 32'h1234, 4'h3);
        apb(1'b1, 8'h0c, 32'hab99, 4'h2);
        rreg(8'h0c, 32'hab34, "w3 high lane");
        apb(1'b1, 8'h0c, 32'h0077, 4'h1);
        rreg(8'h0c, 32'hab77, "w3 low lane");
        @(posedge mclk);
        {wr_en, wr_byte, wr_addr, wr_data} <= {2'b11, 4'h3, 16'h5566};
        {rd_addr_a, rd_addr_b} <= 8'h33;
        @(posedge mclk);
        {wr_en, wr_byte} <= 2'b00;
        repeat (2) @(posedge mclk);
        check("w3 byte write", rd_data_a, 16'hab66);
        check("w3 port b", rd_data_b, 16'hab66);
        $display("test lanes done");
        apb(1'b1, 8'h44, 32'h5555, 4'hf);
        rreg(8'h44, 32'h0, "unmapped data");
        check("unmapped err", rerr, 1'b1);
        apb(1'b0, 8'h0e, 32'h0, 4'h0);
        check("unaligned err", rerr, 1'b1);
        $display("test map done");
        fill(16'h1100);
        ctx_in <= {8'h3c, 8'h5a, 5'h15};
        ev(5);
        ctx_in <= '0;
        fill(16'h2200);
        ev(6);
        check("ctx restore", ctx_restore, 1'b1);
        check("ctx out", ctx_out, {8'h3c, 8'h5a, 5'h15});
        for (int i = 0; i < 15; i++)
            rreg(8'(4 * i), 32'h1100 + 32'(i), "shadow reg");
        check("fp view", frame_pointer_reg, 16'h110e);
        check("reg0 view", implied_working_reg, 16'h1100);
        $display("test shadow done");
        loop_in <= {1'b1, 24'h012346, 24'h01a000, 16'h0009};
        ev(7);
        loop_in <= '0;
        ev(8);
        check("loop restore", loop_restore, 1'b1);
        check("loop out", loop_out,
            {1'b1, 24'h012346, 24'h01a000, 16'h9});
        $display("test loop done");
        apb(1'b1, WRSL_OFS_LIMIT, 32'h0c03, 4'hf);
        rreg(WRSL_OFS_LIMIT, 32'h0c02, "limit bit0");
        apb(1'b1, 8'h3c, 32'h0c01, 4'h3);
        rreg(8'h3c, 32'h0c00, "stkptr bit0");
        for (int i = 0; i < 3; i++)
        begin
            push_data <= 16'h7000 + 16'(i);
            ev(0);
            check("push addr", stk_addr, 16'h0c00 + 16'(2 * i));
            check("push data", stk_wdata, 16'h7000 + 16'(i));
            check("push req", {stk_req, stk_we}, 2'b11);
            check("push ovf", ovf_trap, i == 2);
        end
        @(posedge mclk);
        check("ovf one cycle", ovf_trap, 1'b0);
        ev(1);
        check("pop addr", {stk_req, stk_we, stk_addr}, 18'h20c04);
        rreg(8'h3c, 32'h0c04, "stkptr after pop");
        look_addr <= 16'h0c02;
        @(posedge mclk);
        check("stack word", look_data, 16'h7001);
        ea(16'h0c02, 1'b0, 1'b0);
        ea(16'h0c04, 1'b1, 1'b0);
        $display("test overflow done");
        apb(1'b1, 8'h3c, 32'h0800, 4'h3);
        ev(1);
        check("floor pop", stk_addr, 16'h07fe);
        check("pop unf", unf_trap, 1'b1);
        ea(16'h0800, 1'b0, 1'b0);
        ea(16'h07fe, 1'b0, 1'b1);
        $display("test underflow done");
        apb(1'b1, 8'h3c, 32'h0900, 4'h3);
        pc_value <= PCV;
        status_low_byte <= 8'ha5;
        for (int j = 0; j < 2; j++)
        begin
            ev(2 + j);
            check("pc low", {stk_req, stk_busy, stk_addr, stk_wdata},
                {2'b11, 16'h0900 + 16'(4 * j), PCV[15:1], 1'b0});
            @(posedge mclk);
            check("pc high", {stk_req, stk_busy, stk_addr, stk_wdata},
                {2'b10, 16'h0902 + 16'(4 * j), (j == 1) ? 8'ha5 : 8'h00,
                1'b0, PCV[22:16]});
        end
        rreg(8'h3c, 32'h0908, "stkptr after pc");
        $display("test pc push done");
        ce <= 1'b0;
        ev(0);
        check("frozen push", {stk_req, stack_top_pointer},
            17'h00908);
        ce <= 1'b1;
        $display("test freeze done");
        stop_test();
    end
endmodule
